// [ccfa_align.sv]
// Control-channel frame, multiframe and bit-phase alignment with APB registers
//
// What this block does
// - Frames and multiframes are placed relative to the first detected sync.
// - Bit phase at first sync comes from the two top bits of the phase offset.
// - Programmed offsets describe the ideal phase that begins at that falling clock edge.
// - Edge select 0: sync on falling edge; 1: rising, next falling is the point.
// - Input data is sampled on the falling edge starting bit phase 2.
// - Output data and enable launch on the falling edge starting bit phase 0.
// - Multiframe preset names the first complete frame starting at or after the sync.
// - Reflect mode passes input to output directly, without retiming.
// - Sync is low active; four clock phases per bit, 2048 kbit/s.
`timescale 1ns/10ps
`default_nettype none
module ccfa_align (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccfa_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins
  input wire logic system_bit_clock,
  input wire logic frame_sync_n,
  input wire logic cc_in,
  output logic cc_out,
  output logic cc_out_en
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_pipe_r;
  logic rst_int_n;

  // Asynchronous assert, release after two clean edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_int_n = rst_pipe_r[1];

  // ****************************************
  // Pin sampling
  // ****************************************
  logic lclk_s;
  logic sync_n_s;
  logic din_s;
  logic fall_p;
  logic rise_p;

  // All three pins share one synchroniser so they stay aligned
  ccfa_sync2 #(.W(3)) u_sync (
    .clk(clk),
    .rst_n(rst_int_n),
    .d({system_bit_clock, frame_sync_n, cc_in}),
    .q({lclk_s, sync_n_s, din_s})
  );

  ccfa_edge u_edge (
    .clk(clk),
    .rst_n(rst_int_n),
    .lclk(lclk_s),
    .fall(fall_p),
    .rise(rise_p)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [7:0] fofs_r, fofs_nxt;
  logic [ccfa_pkg::FR_W-1:0] mfr_r, mfr_nxt;
  logic [7:0] phofs_r, phofs_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic [ccfa_pkg::CH_W-1:0] tx_ch_r, tx_ch_nxt;
  logic tx_en_r, tx_en_nxt;
  logic [ccfa_pkg::CH_W-1:0] rx_ch_r, rx_ch_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Alignment state, declared here because the status read needs it
  logic [ccfa_pkg::PH_W-1:0] ph_r, ph_nxt;
  logic [ccfa_pkg::BIT_W-1:0] bit_r, bit_nxt;
  logic [ccfa_pkg::CH_W-1:0] ch_r, ch_nxt;
  logic [ccfa_pkg::FR_W-1:0] fr_r, fr_nxt;
  logic synced_r, synced_nxt;
  logic err_r, err_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] rx_byte_r, rx_byte_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;

  // One wait state lets read data come from a flop
  assign wr_en = psel & penable & pready_r & pwrite;
  assign rd_en = psel & penable & pready_r & ~pwrite;

  // Address decode and read data selection
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ccfa_pkg::OFS_CTRL: rd_mux[2:0] = ctrl_r;
      ccfa_pkg::OFS_FRAME_OFS: rd_mux[7:0] = fofs_r;
      ccfa_pkg::OFS_MFR: rd_mux[ccfa_pkg::FR_W-1:0] = mfr_r;
      ccfa_pkg::OFS_PHASE: rd_mux[7:0] = phofs_r;
      ccfa_pkg::OFS_TX: begin
        rd_mux[7:0] = tx_byte_r;
        rd_mux[ccfa_pkg::SEL_CH_LSB +: ccfa_pkg::CH_W] = tx_ch_r;
        rd_mux[ccfa_pkg::TX_EN_BIT] = tx_en_r;
      end
      ccfa_pkg::OFS_RX: begin
        rd_mux[7:0] = rx_byte_r;
        rd_mux[ccfa_pkg::SEL_CH_LSB +: ccfa_pkg::CH_W] = rx_ch_r;
        rd_mux[ccfa_pkg::RX_VALID_BIT] = rx_valid_r;
      end
      ccfa_pkg::OFS_STATUS: begin
        rd_mux[ccfa_pkg::STAT_SYNCED_BIT] = synced_r;
        rd_mux[ccfa_pkg::STAT_ERR_BIT] = err_r;
        rd_mux[ccfa_pkg::STAT_PH_LSB +: ccfa_pkg::PH_W] = ph_r;
        rd_mux[ccfa_pkg::STAT_BIT_LSB +: ccfa_pkg::BIT_W] = bit_r;
        rd_mux[ccfa_pkg::STAT_CH_LSB +: ccfa_pkg::CH_W] = ch_r;
        rd_mux[ccfa_pkg::STAT_FR_LSB +: ccfa_pkg::FR_W] = fr_r;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // Bus handshake and software-written fields
  always_comb begin
    ctrl_nxt = ctrl_r;
    fofs_nxt = fofs_r;
    mfr_nxt = mfr_r;
    phofs_nxt = phofs_r;
    tx_byte_nxt = tx_byte_r;
    tx_ch_nxt = tx_ch_r;
    tx_en_nxt = tx_en_r;
    rx_ch_nxt = rx_ch_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & penable & ~pready_r;
    if (psel && penable && !pready_r) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_nxt = ~addr_ok;
    end
    if (wr_en) begin
      case (paddr)
        ccfa_pkg::OFS_CTRL: ctrl_nxt = pwdata[2:0];
        ccfa_pkg::OFS_FRAME_OFS: fofs_nxt = pwdata[7:0];
        ccfa_pkg::OFS_MFR: mfr_nxt = pwdata[ccfa_pkg::FR_W-1:0];
        ccfa_pkg::OFS_PHASE: phofs_nxt = pwdata[7:0];
        ccfa_pkg::OFS_TX: begin
          tx_byte_nxt = pwdata[7:0];
          tx_ch_nxt = pwdata[ccfa_pkg::SEL_CH_LSB +: ccfa_pkg::CH_W];
          tx_en_nxt = pwdata[ccfa_pkg::TX_EN_BIT];
        end
        ccfa_pkg::OFS_RX: rx_ch_nxt = pwdata[ccfa_pkg::SEL_CH_LSB +: ccfa_pkg::CH_W];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ctrl_r <= ccfa_pkg::CTRL_RST;
      fofs_r <= ccfa_pkg::FRAME_OFS_RST;
      mfr_r <= ccfa_pkg::MFR_RST;
      phofs_r <= ccfa_pkg::PHASE_RST;
      tx_byte_r <= ccfa_pkg::BYTE_RST;
      tx_ch_r <= ccfa_pkg::SEL_RST;
      tx_en_r <= 1'b0;
      rx_ch_r <= ccfa_pkg::SEL_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      fofs_r <= fofs_nxt;
      mfr_r <= mfr_nxt;
      phofs_r <= phofs_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_ch_r <= tx_ch_nxt;
      tx_en_r <= tx_en_nxt;
      rx_ch_r <= rx_ch_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Alignment counters
  // ****************************************
  logic enable;
  logic edge_sel;
  logic sync_pt;
  logic at_start;
  logic [ccfa_pkg::PH_W-1:0] ld_ph;
  logic [ccfa_pkg::BIT_W-1:0] ld_bit;
  logic [ccfa_pkg::CH_W-1:0] ld_ch;
  logic [ccfa_pkg::FR_W-1:0] ld_fr;
  logic [ccfa_pkg::PH_W-1:0] adv_ph;
  logic [ccfa_pkg::BIT_W-1:0] adv_bit;
  logic [ccfa_pkg::CH_W-1:0] adv_ch;
  logic [ccfa_pkg::FR_W-1:0] adv_fr;

  assign enable = ctrl_r[ccfa_pkg::CTRL_EN_BIT];
  assign edge_sel = ctrl_r[ccfa_pkg::CTRL_EDGE_BIT];

  // Preload values for the phase that begins at the sync edge
  always_comb begin
    ld_ph = phofs_r[ccfa_pkg::PHASE_MSB_LSB +: ccfa_pkg::PH_W];
    ld_bit = ccfa_pkg::BIT_FIRST - fofs_r[ccfa_pkg::FOFS_BIT_LSB +: ccfa_pkg::BIT_W];
    ld_ch = fofs_r[ccfa_pkg::FOFS_CH_LSB +: ccfa_pkg::CH_W];
    at_start = (ld_ph == ccfa_pkg::PH_LAUNCH) && (ld_bit == ccfa_pkg::BIT_FIRST) && (ld_ch == '0);
    // The preset belongs to the next frame that starts cleanly
    ld_fr = at_start ? mfr_r : mfr_r - 5'h01;
  end

  // Advance by one clock phase with wrap at bit, channel, frame, multiframe
  always_comb begin
    adv_ph = ph_r + 2'h1;
    adv_bit = bit_r;
    adv_ch = ch_r;
    adv_fr = fr_r;
    if (ph_r == ccfa_pkg::PH_LAST) begin
      adv_bit = bit_r - 3'h1;
      if (bit_r == '0) begin
        adv_ch = (ch_r == ccfa_pkg::CH_LAST) ? '0 : ch_r + 5'h01;
        if (ch_r == ccfa_pkg::CH_LAST) begin
          adv_fr = (fr_r == ccfa_pkg::FR_LAST) ? '0 : fr_r + 5'h01;
        end
      end
    end
  end

  // Sync point: falling edge directly, or the falling edge after a rising-edge sample
  always_comb begin
    pend_nxt = pend_r;
    sync_pt = 1'b0;
    if (!enable) begin
      pend_nxt = 1'b0;
    end else if (!edge_sel) begin
      sync_pt = fall_p & ~sync_n_s;
      pend_nxt = 1'b0;
    end else begin
      if (rise_p && !sync_n_s) begin
        pend_nxt = 1'b1;
      end
      if (fall_p && pend_r) begin
        sync_pt = 1'b1;
        pend_nxt = 1'b0;
      end
    end
  end

  // Counter state, sync status and serial data
  always_comb begin
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    ch_nxt = ch_r;
    fr_nxt = fr_r;
    synced_nxt = synced_r;
    err_nxt = err_r;
    rx_sh_nxt = rx_sh_r;
    rx_byte_nxt = rx_byte_r;
    rx_valid_nxt = rx_valid_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    // Software clears the error flag by writing one and the RX valid flag by reading RX; a new event in the same cycle wins
    if (wr_en && paddr == ccfa_pkg::OFS_STATUS && pwdata[ccfa_pkg::STAT_ERR_BIT]) begin
      err_nxt = 1'b0;
    end
    if (rd_en && paddr == ccfa_pkg::OFS_RX) begin
      rx_valid_nxt = 1'b0;
    end
    if (!enable) begin
      synced_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (fall_p) begin
      if (sync_pt && !synced_r) begin
        // Only the first sync places the frame
        ph_nxt = ld_ph;
        bit_nxt = ld_bit;
        ch_nxt = ld_ch;
        fr_nxt = ld_fr;
        synced_nxt = 1'b1;
      end else begin
        ph_nxt = adv_ph;
        bit_nxt = adv_bit;
        ch_nxt = adv_ch;
        fr_nxt = adv_fr;
        // A later sync off the multiframe grid means the partner broke the period
        if (sync_pt && (adv_ph != ld_ph || adv_bit != ld_bit || adv_ch != ld_ch || adv_fr != ld_fr)) begin
          err_nxt = 1'b1;
        end
      end
      if (synced_nxt && ph_nxt == ccfa_pkg::PH_SAMPLE) begin
        rx_sh_nxt = {rx_sh_r[6:0], din_s};
        if (bit_nxt == '0 && ch_nxt == rx_ch_r) begin
          rx_byte_nxt = {rx_sh_r[6:0], din_s};
          rx_valid_nxt = 1'b1;
        end
      end
      if (synced_nxt && ph_nxt == ccfa_pkg::PH_LAUNCH) begin
        oe_nxt = tx_en_r && (ch_nxt == tx_ch_r);
        out_nxt = oe_nxt ? tx_byte_r[bit_nxt] : 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ph_r <= '0;
      bit_r <= ccfa_pkg::BIT_FIRST;
      ch_r <= '0;
      fr_r <= '0;
      synced_r <= 1'b0;
      err_r <= 1'b0;
      pend_r <= 1'b0;
      rx_sh_r <= ccfa_pkg::BYTE_RST;
      rx_byte_r <= ccfa_pkg::BYTE_RST;
      rx_valid_r <= 1'b0;
      out_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      ch_r <= ch_nxt;
      fr_r <= fr_nxt;
      synced_r <= synced_nxt;
      err_r <= err_nxt;
      pend_r <= pend_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_valid_r <= rx_valid_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ****************************************
  // Output path
  // ****************************************
  // Reflect is a raw pin-to-pin path by design, so it bypasses the output flops
  assign cc_out = ctrl_r[ccfa_pkg::CTRL_REFLECT_BIT] ? cc_in : out_r;
  assign cc_out_en = ctrl_r[ccfa_pkg::CTRL_REFLECT_BIT] | oe_r;

endmodule
`default_nettype wire

// [ccfa_pkg.sv]
// Constants for the control-channel frame alignment block
package ccfa_pkg;

  // ****************************************
  // Link timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int LINK_CLK_KHZ = 8192;
  localparam int BIT_RATE_KBPS = 2048;
  localparam int FRAME_PERIOD_US = 125;
  localparam int MF_PERIOD_US = 4000;
  localparam int PHASES_PER_BIT = LINK_CLK_KHZ / BIT_RATE_KBPS;
  localparam int BITS_PER_CH = 8;
  localparam int CH_PER_FRAME = BIT_RATE_KBPS * FRAME_PERIOD_US / 1000 / BITS_PER_CH;
  localparam int FRAMES_PER_MF = MF_PERIOD_US / FRAME_PERIOD_US;

  // Counter widths
  localparam int PH_W = 2;
  localparam int BIT_W = 3;
  localparam int CH_W = 5;
  localparam int FR_W = 5;
  localparam logic [PH_W-1:0] PH_LAST = 2'(PHASES_PER_BIT - 1);
  localparam logic [PH_W-1:0] PH_SAMPLE = 2'h2;
  localparam logic [PH_W-1:0] PH_LAUNCH = 2'h0;
  localparam logic [BIT_W-1:0] BIT_FIRST = 3'(BITS_PER_CH - 1);
  localparam logic [CH_W-1:0] CH_LAST = 5'(CH_PER_FRAME - 1);
  localparam logic [FR_W-1:0] FR_LAST = 5'(FRAMES_PER_MF - 1);

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_FRAME_OFS = 8'h04;
  localparam logic [APB_AW-1:0] OFS_MFR = 8'h08;
  localparam logic [APB_AW-1:0] OFS_PHASE = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_TX = 8'h10;
  localparam logic [APB_AW-1:0] OFS_RX = 8'h14;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_REFLECT_BIT = 2;
  localparam int FOFS_BIT_LSB = 0;
  localparam int FOFS_CH_LSB = 3;
  localparam int PHASE_MSB_LSB = 6;
  localparam int SEL_CH_LSB = 8;
  localparam int TX_EN_BIT = 16;
  localparam int RX_VALID_BIT = 16;
  localparam int STAT_SYNCED_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_PH_LSB = 2;
  localparam int STAT_BIT_LSB = 4;
  localparam int STAT_CH_LSB = 8;
  localparam int STAT_FR_LSB = 16;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] FRAME_OFS_RST = 8'h00;
  localparam logic [FR_W-1:0] MFR_RST = 5'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [CH_W-1:0] SEL_RST = 5'h00;

endpackage

// [ccfa_sync2.sv]
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module ccfa_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [ccfa_edge.sv]
// Edge finder for the sampled system bit clock
`timescale 1ns/10ps
`default_nettype none
module ccfa_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sampled link clock
  input wire logic lclk,
  // One-cycle edge strobes
  output logic fall,
  output logic rise
);

  logic prev_r;

  // Previous level; strobes are combinational so they line up with data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lclk;
    end
  end

  assign fall = prev_r & ~lclk;
  assign rise = ~prev_r & lclk;

endmodule
`default_nettype wire

// [ccfa_align_monitor.sv]
// Port-level checks for the frame alignment block
`timescale 1ns/10ps
`default_nettype none
module ccfa_align_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccfa_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link pins
  input wire logic system_bit_clock,
  input wire logic frame_sync_n,
  input wire logic cc_in,
  input wire logic cc_out,
  input wire logic cc_out_en
);
  // ****************************************
  // Shadow of the control bits
  // ****************************************
  logic wr_ctrl;
  logic en_r, en_nxt, refl_r, refl_nxt;
  logic [5:0] dis_r, dis_nxt;

  // Mirror CTRL writes, so the mode is known without looking inside
  always_comb begin
    wr_ctrl = psel && penable && pready && pwrite && paddr == ccfa_pkg::OFS_CTRL;
    en_nxt = wr_ctrl ? pwdata[ccfa_pkg::CTRL_EN_BIT] : en_r;
    refl_nxt = wr_ctrl ? pwdata[ccfa_pkg::CTRL_REFLECT_BIT] : refl_r;
    dis_nxt = en_r ? 6'h00 : (dis_r == 6'h3f ? dis_r : dis_r + 6'h01);
  end

  // Disabled time saturates, well beyond one bit of 32 cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      refl_r <= 1'b0;
      dis_r <= 6'h00;
    end else begin
      en_r <= en_nxt;
      refl_r <= refl_nxt;
      dis_r <= dis_nxt;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  rdy_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing in second access cycle");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdy_in_xfer_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ccfa_pkg::OFS_STATUS))
    else $error("pslverr does not match address decode");
  wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("prdata not zero on a write");
  rst_idle_a: assert property ($rose(rst_n) |-> !pready && !pslverr && !cc_out_en && cc_out)
    else $error("outputs not idle right after reset");
  reflect_path_a: assert property (refl_r |-> cc_out == cc_in && cc_out_en)
    else $error("reflect path broken");
  launch_hold_a: assert property (
    en_r && !refl_r && $stable(en_r) && ($changed(cc_out) || $changed(cc_out_en))
    |=> ($stable(cc_out) && $stable(cc_out_en))[*8])
    else $error("link output changed within a bit");
  oe_off_a: assert property (dis_r == 6'h3f && !refl_r |-> !cc_out_en)
    else $error("output enable while disabled");
endmodule

bind ccfa_align ccfa_align_monitor mon (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .system_bit_clock(system_bit_clock), .frame_sync_n(frame_sync_n), .cc_in(cc_in),
  .cc_out(cc_out), .cc_out_en(cc_out_en)
);
`default_nettype wire

// [ccfa_link_model.sv]
// Far-side switching logic: free bit clock, frame sync and serial data
`timescale 1ns/10ps
`default_nettype none
module ccfa_link_model (
  // Requests from the bench
  input wire logic send,
  input wire logic edge_mode,
  input wire logic [1:0] ph0,
  // Link pins
  output logic system_bit_clock,
  output logic frame_sync_n,
  output logic cc_in,
  // High at the falling edge that is the sync point
  output logic sync_mark
);
  // Asymmetric pattern, so a reversed bit order shows
  localparam logic [7:0] rx_byte = 8'hc5;
  int ph = 0;
  int bitn = 7;
  bit run = 1'b0;

  // Bit clock of 80 ns runs free, each edge 2 ns before a system clock rising edge
  initial begin
    system_bit_clock = 1'b1;
    frame_sync_n = 1'b1;
    cc_in = 1'b0;
    sync_mark = 1'b0;
    #3;
    forever #40 system_bit_clock = ~system_bit_clock;
  end

  // One low pulse per request; the bench asks again well within 4 ms to provoke a sync error
  always @(posedge send) begin
    @(negedge system_bit_clock);
    #10 frame_sync_n = 1'b0;
    if (edge_mode) begin
      @(posedge system_bit_clock);
      #20 frame_sync_n = 1'b1;
    end
    @(negedge system_bit_clock);
    run = 1'b1;
    ph = ph0;
    bitn = 7;
    sync_mark = 1'b1;
    #20;
    frame_sync_n = 1'b1;
    sync_mark = 1'b0;
  end

  // Data moves just after phase 0 begins, steady at the phase 2 sample
  always @(negedge system_bit_clock) begin
    // Kept off the system clock edges, which fall 2 ns after each link clock edge
    #1;
    if (!run) begin
      cc_in = ~cc_in;
    end else begin
      if (ph == 0) begin
        cc_in = rx_byte[bitn];
      end
      if (ph == 3) begin
        bitn = (bitn + 7) % 8;
      end
      ph = (ph + 1) % 4;
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the frame alignment block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and rows
  // ****************************************
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, send, emode, sync_mark;
  logic pready, pslverr, err, sbc, fsync_n, cc_in, cc_out, cc_out_en;
  logic [7:0] paddr, byt;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ph0;
  int fail_count = 0;
  int checks = 0;
  int n;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ccfa_row_s;
  localparam logic [31:0] zero = 32'h0000_0000;
  ccfa_row_s rows [13] = '{
    '{1'b0, 8'h00, zero, zero, 1'b0},
    '{1'b0, 8'h04, zero, zero, 1'b0},
    '{1'b0, 8'h08, zero, zero, 1'b0},
    '{1'b0, 8'h0c, zero, zero, 1'b0},
    '{1'b0, 8'h10, zero, zero, 1'b0},
    '{1'b0, 8'h1c, zero, zero, 1'b1},
    '{1'b1, 8'h1c, 32'hffff_ffff, zero, 1'b1},
    '{1'b1, 8'h04, 32'hffff_ff5a, zero, 1'b0},
    '{1'b0, 8'h04, zero, 32'h0000_005a, 1'b0},
    '{1'b1, 8'h08, 32'hffff_ffff, zero, 1'b0},
    '{1'b0, 8'h08, zero, 32'h0000_001f, 1'b0},
    '{1'b1, 8'h0c, 32'h0000_00c0, zero, 1'b0},
    '{1'b0, 8'h0c, zero, 32'h0000_00c0, 1'b0}};

  always #5 clk = ~clk;

  ccfa_align dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_bit_clock(sbc), .frame_sync_n(fsync_n), .cc_in(cc_in), .cc_out(cc_out),
    .cc_out_en(cc_out_en));
  ccfa_link_model far (.send(send), .edge_mode(emode), .ph0(ph0), .system_bit_clock(sbc),
    .frame_sync_n(fsync_n), .cc_in(cc_in), .sync_mark(sync_mark));

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready, never for a fixed count
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Enable is written last, so the sync always finds a full setup
  task cfg(input logic [31:0] fo, ph, mf, tx, ct);
    apb(1'b1, ccfa_pkg::OFS_FRAME_OFS, fo);
    apb(1'b1, ccfa_pkg::OFS_PHASE, ph);
    apb(1'b1, ccfa_pkg::OFS_MFR, mf);
    apb(1'b1, ccfa_pkg::OFS_TX, tx);
    apb(1'b1, ccfa_pkg::OFS_RX, zero);
    apb(1'b1, ccfa_pkg::OFS_CTRL, ct);
  endtask

  // Sync, then time the transmit channel from the sync point and catch its byte
  task run_link(input logic m, input logic [1:0] p, input int dly);
    emode <= m;
    ph0 <= p;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge sync_mark);
    n = 0;
    while (cc_out_en !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("launch delay", 32'(n >= dly + 2 && n <= dly + 7), 32'h0000_0001);
    repeat (16) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      byt[i] = cc_out;
      repeat (32) @(posedge clk);
    end
    chk("oe after channel", 32'(cc_out_en), zero);
  endtask

  task status(input logic [31:0] fr);
    apb(1'b0, ccfa_pkg::OFS_STATUS, zero);
    chk("synced", 32'(rd[ccfa_pkg::STAT_SYNCED_BIT]), 32'h0000_0001);
    chk("frame", 32'(rd[ccfa_pkg::STAT_FR_LSB +: 5]), fr);
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = zero;
    send = 1'b0;
    emode = 1'b0;
    ph0 = 2'h0;
    do_reset();
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("prdata", rd, rows[i].x);
      chk("pslverr", 32'(err), 32'(rows[i].e));
    end
    $display("register table test done");
    // Reflect: output follows the toggling input with no clock between
    apb(1'b1, ccfa_pkg::OFS_CTRL, 32'h0000_0004);
    repeat (6) begin
      // Look before the next clk edge, so a flopped path would still lag
      @(negedge sbc);
      #1.5;
      chk("reflect out", 32'(cc_out), 32'(cc_in));
      chk("reflect oe", 32'(cc_out_en), 32'h0000_0001);
    end
    apb(1'b1, ccfa_pkg::OFS_CTRL, zero);
    $display("reflect test done");
    // Sync on the falling edge, all offsets zero, preset 3
    cfg(zero, zero, 32'h0000_0003, 32'h0001_01a5, 32'h0000_0001);
    run_link(1'b0, 2'h0, 256);
    chk("tx byte", 32'(byt), 32'h0000_00a5);
    apb(1'b0, ccfa_pkg::OFS_RX, zero);
    chk("rx word", rd, 32'h0001_00c5);
    apb(1'b0, ccfa_pkg::OFS_RX, zero);
    chk("rx cleared", rd, 32'h0000_00c5);
    status(32'h0000_0003);
    $display("falling edge sync test done");
    // Reset in mid-traffic, then rising-edge sync at phase 2, bit 6
    do_reset();
    apb(1'b0, ccfa_pkg::OFS_CTRL, zero);
    chk("ctrl after reset", rd, zero);
    cfg(32'h0000_0001, 32'h0000_0080, 32'h0000_0005, 32'h0001_023c, 32'h0000_0003);
    run_link(1'b1, 2'h2, 464);
    chk("tx byte", 32'(byt), 32'h0000_003c);
    status(32'h0000_0004);
    $display("rising edge offset sync test done");
    // A second sync off the multiframe grid must flag an error; writing one clears it
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge sync_mark);
    repeat (40) @(posedge clk);
    apb(1'b0, ccfa_pkg::OFS_STATUS, zero);
    chk("sync error", 32'(rd[ccfa_pkg::STAT_ERR_BIT]), 32'h0000_0001);
    chk("frame kept", 32'(rd[ccfa_pkg::STAT_FR_LSB +: 5]), 32'h0000_0004);
    apb(1'b1, ccfa_pkg::OFS_STATUS, 32'h0000_0002);
    apb(1'b0, ccfa_pkg::OFS_STATUS, zero);
    chk("sync error cleared", 32'(rd[ccfa_pkg::STAT_ERR_BIT]), zero);
    $display("sync error test done");
    test_done();
  end

  // Watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    test_done();
  end
endmodule
`default_nettype wire
